/* File: core/usp_serial_port.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1: bit rate is osc over 16/8/2 times divider+1
// RULE2: twelve bit divider split high low
// RULE3: double speed: eight samples per bit
// RULE4: software keeps double speed off in sync
// RULE5: slave clock synchronised, edge detected, two cycles
// RULE6: slave clock below quarter of oscillator
// RULE7: clock pin output as master, input slave
// RULE8: sample on edge opposite to change
// RULE9: polarity picks change and sample edges
// RULE10: five to nine data, parity, stop options
// RULE11: start, data lsb first, parity, stops
// RULE12: start low, stop high, idle high
// RULE13: complete flag when frame out, buffer empty
// RULE14: complete flag clears on service or one
// RULE15: complete interrupt when enabled and flag set
// RULE16: parity inserted before first stop bit
// RULE17: transmitter disable waits until all empty
// RULE18: receive fifo holds ninth bit and flags
// RULE19: software reads status before low data
// RULE20: receive bit by three sample majority
// RULE21: only first stop checked, frame error
// RULE22: even or odd parity over data
// RULE23: synchronous reset clears all, line idle
module usp_serial_port (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rstn,
    input  wire logic                         i_sync_rst,           // synchronous clear of everything
    input  wire logic [3:0]                   i_baud_divider_high,
    input  wire logic [7:0]                   i_baud_divider_low,
    input  wire logic                         i_double_speed_sel,
    input  wire logic                         i_sync_mode_sel,
    input  wire logic                         i_clock_master_sel,   // sync only: 1 drives the clock
    input  wire logic                         i_clock_polarity_sel,
    input  wire logic [1:0]                   i_parity_mode,        // upper enables, lower selects odd
    input  wire logic                         i_stop_two_sel,
    input  wire logic [2:0]                   i_character_size_code,
    input  wire logic                         i_transmitter_enable,
    input  wire logic                         i_receiver_enable,
    input  wire logic [usp_pkg::DATA_W-1:0]   i_serial_data_reg,    // transmit character
    input  wire logic                         i_transmit_ninth_bit,
    input  wire logic                         i_tx_write,
    output logic                              o_tx_ready,
    input  wire logic                         i_txc_clear,          // software writes one
    input  wire logic                         i_txc_irq_ack,        // interrupt serviced
    input  wire logic                         i_transmit_complete_irq_en,
    input  wire logic                         i_global_irq_en,
    output logic                              o_transmit_complete_flag,
    output logic                              o_txc_irq,
    input  wire logic                         i_rxd,
    output logic                              o_txd,
    output logic                              o_txd_oe,
    input  wire logic                         i_serial_clock_pin,
    output logic                              o_serial_clock_pin,
    output logic                              o_serial_clock_pin_oe,
    input  wire logic                         i_rx_read,            // read of received data
    output logic                              o_rx_valid,
    output logic [usp_pkg::DATA_W-1:0]        o_rx_data,
    output logic                              o_received_ninth_bit,
    output logic                              o_frame_error_flag,
    output logic                              o_overrun_flag,
    output logic                              o_parity_error_flag
);
    import usp_pkg::*;

    // whole block state in one record
    typedef struct packed {
        logic [DIV_W-1:0]   brg_cnt;      // baud down counter
        logic               sclk;         // master clock level
        logic               s1;           // slave clock synchroniser stage 1
        logic               s2;           // stage 2
        logic               s3;           // edge detector history
        logic               transmitter_enable;         // effective transmitter enable
        logic               tx_busy;
        logic [FRAME_W-1:0] tx_shift;
        logic [3:0]         tx_left;      // bits still to send
        logic [3:0]         tx_smp;
        logic               tx_buf_full;
        logic [8:0]         tx_buf;
        logic               transmit_complete_flag;
        logic               rx_act;
        logic [3:0]         rx_smp;
        logic [3:0]         rx_bit;
        logic [1:0]         votes;
        logic [8:0]         rx_data;
        logic               rx_par;
        logic               dor_pend;     // a frame was lost, tag the next one
        logic               push;
        logic [FIFO_W-1:0]  push_word;
    } usp_state_t;

    usp_state_t        st_ff;
    usp_state_t        nxt_st;
    logic [DIV_W-1:0]  divider;           // assembled baud divider
    logic              tick;              // baud generator tick
    logic              is_master;
    logic              is_slave;
    logic              rise_evt;          // serial clock edges, either source
    logic              fall_evt;
    logic              change_evt;
    logic              sample_evt;
    logic [3:0]        nbits;
    logic              pen;
    logic              podd;
    logic [3:0]        smp_last;
    logic [3:0]        vote_first;
    logic [3:0]        vote_last;
    logic              fifo_ready;
    logic [FIFO_W-1:0] fifo_word;
    logic              tx_bound;          // end of a transmitted bit
    logic              tx_end;            // end of the last bit of a frame
    logic              decide;
    logic              bitv;
    logic [1:0]        ones;

    // data bits per character code
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        if (code == CSZ_NINE) begin
            char_bits = NBITS_NINE;
        end else if (code[2]) begin
            char_bits = NBITS_EIGHT;    // reserved codes fall back to eight
        end else begin
            char_bits = NBITS_MIN + {2'h0, code[1:0]}; // RULE10
        end
    endfunction

    // parity of the valid data bits, odd flips it
    function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < n) begin
                p = p ^ d[i];           // RULE22
            end
        end
        par_of = p;
    endfunction

    // whole frame, lsb out first, padded with idle ones
    function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                       input logic en, input logic p);
        logic [FRAME_W-1:0] f;
        f    = '1;                      // stop bits and padding high RULE12
        f[0] = 1'b0;                    // start bit RULE11
        for (int i = 0; i < 9; i++) begin
            if (i < n) begin
                f[i+1] = d[i];          // data lsb first RULE11
            end
        end
        if (en) begin
            f[n+1] = p;                 // after last data, before stop RULE16
        end
        build_frame = f;
    endfunction

    assign divider    = {i_baud_divider_high, i_baud_divider_low}; // RULE2
    assign tick       = (st_ff.brg_cnt == '0);
    assign is_master  = i_sync_mode_sel && i_clock_master_sel;
    assign is_slave   = i_sync_mode_sel && !i_clock_master_sel;
    assign nbits      = char_bits(i_character_size_code);
    assign pen        = i_parity_mode[PAR_EN_BIT];
    assign podd       = i_parity_mode[PAR_ODD_BIT];
    // double speed halves the sample count RULE3
    assign smp_last   = i_double_speed_sel ? SMP_LAST_D : SMP_LAST_N;
    assign vote_first = i_double_speed_sel ? VOTE_FIRST_D : VOTE_FIRST_N;
    assign vote_last  = i_double_speed_sel ? VOTE_LAST_D : VOTE_LAST_N;

    // master toggles on each tick, slave uses the delayed synchronised copy
    assign rise_evt   = is_master ? (tick && !st_ff.sclk) : (is_slave && st_ff.s2 && !st_ff.s3); // RULE5
    assign fall_evt   = is_master ? (tick && st_ff.sclk) : (is_slave && !st_ff.s2 && st_ff.s3);
    // polarity low: change falling, sample rising RULE9
    assign change_evt = i_clock_polarity_sel ? rise_evt : fall_evt;   // RULE8
    assign sample_evt = i_clock_polarity_sel ? fall_evt : rise_evt;   // RULE8

    assign tx_bound   = st_ff.tx_busy && (i_sync_mode_sel ? change_evt : (tick && st_ff.tx_smp == smp_last));
    assign tx_end     = tx_bound && (st_ff.tx_left == 4'h1);
    assign ones       = st_ff.votes + {1'b0, i_rxd};

    // receive bit decision, async by vote, sync by one sample
    always_comb begin
        decide = 1'b0;
        bitv   = i_rxd;
        if (st_ff.rx_act) begin
            if (i_sync_mode_sel) begin
                decide = sample_evt;
            end else if (tick && st_ff.rx_smp == vote_last) begin
                decide = 1'b1;
                bitv   = (ones >= 2'h2); // RULE20
            end
        end
    end

    // next state of the whole block
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.push = 1'b0;
        nxt_st.s1   = i_serial_clock_pin;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;

        // baud generator, reload gives divide by divider+1 RULE1
        if (tick) begin
            nxt_st.brg_cnt = divider;
        end else begin
            nxt_st.brg_cnt = st_ff.brg_cnt - 1'b1;
        end
        // master clock: one toggle per tick, so two ticks per bit RULE1
        if (is_master && tick) begin
            nxt_st.sclk = !st_ff.sclk;
        end else if (!is_master) begin
            nxt_st.sclk = SCLK_RST;
        end

        // disabling only lands once shifter and buffer are empty RULE17
        if (i_transmitter_enable) begin
            nxt_st.transmitter_enable = 1'b1;
        end else if (!st_ff.tx_busy && !st_ff.tx_buf_full) begin
            nxt_st.transmitter_enable = 1'b0;
        end

        // transmit buffer write
        if (i_tx_write && o_tx_ready) begin
            nxt_st.tx_buf_full = 1'b1;
            nxt_st.tx_buf      = {i_transmit_ninth_bit, i_serial_data_reg};
        end

        // transmit shifter
        if (tick && st_ff.tx_busy) begin
            nxt_st.tx_smp = (st_ff.tx_smp == smp_last) ? 4'h0 : st_ff.tx_smp + 4'h1;
        end
        if (tx_bound) begin
            nxt_st.tx_shift = {1'b1, st_ff.tx_shift[FRAME_W-1:1]};
            nxt_st.tx_left  = st_ff.tx_left - 4'h1;
        end
        if (tx_end) begin
            nxt_st.tx_busy = 1'b0;
        end
        // load when idle or right behind the last bit, back to back
        if (st_ff.tx_buf_full && (!st_ff.tx_busy || tx_end)) begin
            nxt_st.tx_busy     = 1'b1;
            nxt_st.tx_buf_full = 1'b0;
            nxt_st.tx_smp      = 4'h0;
            nxt_st.tx_shift    = build_frame(st_ff.tx_buf, nbits, pen, par_of(st_ff.tx_buf, nbits, podd));
            nxt_st.tx_left     = 4'h2 + nbits + {3'h0, pen} + {3'h0, i_stop_two_sel};
        end

        // complete flag: clear first so that a new set wins RULE14
        if (i_txc_clear || i_txc_irq_ack) begin
            nxt_st.transmit_complete_flag = 1'b0;
        end
        if (tx_end && !st_ff.tx_buf_full) begin
            nxt_st.transmit_complete_flag = 1'b1;          // RULE13
        end

        // async vote window and sample counter
        if (st_ff.rx_act && !i_sync_mode_sel && tick) begin
            nxt_st.rx_smp = (st_ff.rx_smp == smp_last) ? 4'h0 : st_ff.rx_smp + 4'h1;
            if (st_ff.rx_smp >= vote_first && st_ff.rx_smp < vote_last) begin
                nxt_st.votes = ones;    // RULE20
            end
        end

        // start detection, first low sample counts as sample zero
        if (!st_ff.rx_act && i_receiver_enable && !i_rxd) begin
            if (!i_sync_mode_sel && tick) begin
                nxt_st.rx_act  = 1'b1;
                nxt_st.rx_smp  = 4'h1;
                nxt_st.rx_bit  = 4'h0;
                nxt_st.votes   = 2'h0;
                nxt_st.rx_data = '0;
            end else if (i_sync_mode_sel && sample_evt) begin
                nxt_st.rx_act  = 1'b1;
                nxt_st.rx_bit  = 4'h1;  // start bit already taken
                nxt_st.rx_data = '0;
            end
        end

        // per bit handling
        if (decide) begin
            nxt_st.votes  = 2'h0;
            nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
            if (st_ff.rx_bit == 4'h0) begin
                if (bitv) begin
                    nxt_st.rx_act = 1'b0;   // glitch, not a start bit
                end
            end else if (st_ff.rx_bit <= nbits) begin
                nxt_st.rx_data[st_ff.rx_bit - 4'h1] = bitv;
            end else if (pen && st_ff.rx_bit == nbits + 4'h1) begin
                nxt_st.rx_par = bitv;
            end else begin
                // first stop only, then free for the next start RULE21
                nxt_st.rx_act = 1'b0;
                if (fifo_ready) begin
                    nxt_st.push                = 1'b1;
                    nxt_st.dor_pend            = 1'b0;
                    nxt_st.push_word           = '0;
                    nxt_st.push_word[FW_NINTH:0] = st_ff.rx_data;
                    nxt_st.push_word[FW_FE]    = !bitv; // RULE21
                    nxt_st.push_word[FW_DOR]   = st_ff.dor_pend;
                    nxt_st.push_word[FW_PE]    = pen && par_of(st_ff.rx_data, nbits, podd) != st_ff.rx_par;
                end else begin
                    nxt_st.dor_pend = 1'b1; // fifo full, character lost
                end
            end
        end

        if (i_sync_rst) begin
            nxt_st = '0;                // RULE23
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // receive fifo, one read advances data and flags together
    usp_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rstn      (i_rstn),
        .i_clr       (i_sync_rst),
        .i_in_valid  (st_ff.push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (st_ff.push_word),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_read),       // RULE18
        .o_out_data  (fifo_word)
    );

    // outputs
    assign o_rx_data               = fifo_word[DATA_W-1:0];
    assign o_received_ninth_bit    = fifo_word[FW_NINTH];
    assign o_frame_error_flag      = fifo_word[FW_FE];
    assign o_overrun_flag          = fifo_word[FW_DOR];
    assign o_parity_error_flag     = fifo_word[FW_PE];
    assign o_tx_ready              = st_ff.transmitter_enable && !st_ff.tx_buf_full;
    assign o_txd                   = st_ff.tx_busy ? st_ff.tx_shift[0] : TXD_IDLE; // RULE12
    assign o_txd_oe                = st_ff.transmitter_enable;  // RULE17
    assign o_serial_clock_pin      = st_ff.sclk;
    assign o_serial_clock_pin_oe   = is_master;   // RULE7
    assign o_transmit_complete_flag = st_ff.transmit_complete_flag;
    assign o_txc_irq               = st_ff.transmit_complete_flag && i_transmit_complete_irq_en && i_global_irq_en; // RULE15

    // checks
    brg_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE2
        tick && !i_sync_rst |=> st_ff.brg_cnt == $past(divider)) else $error("divider not reloaded");
    master_toggle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE7
        is_master && tick && !i_sync_rst ##1 is_master |-> o_serial_clock_pin != $past(o_serial_clock_pin))
        else $error("master clock did not toggle");
    slave_sync_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE5
        is_slave && $rose(st_ff.s1) ##1 is_slave |-> rise_evt) else $error("slave edge latency wrong");
    txc_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE13
        tx_end && !st_ff.tx_buf_full && !i_sync_rst |=> o_transmit_complete_flag) else $error("complete missing");
    txc_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE14
        st_ff.transmit_complete_flag && i_txc_clear && !tx_end |=> !o_transmit_complete_flag) else $error("complete not cleared");
    txc_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE15
        $rose(st_ff.transmit_complete_flag) && i_transmit_complete_irq_en && i_global_irq_en |-> o_txc_irq)
        else $error("complete interrupt missing");
    start_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE11
        $rose(st_ff.tx_busy) |-> !o_txd) else $error("frame not opened by low start");
    idle_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE12
        !st_ff.tx_busy |-> o_txd) else $error("idle line not high");
    transmitter_enable_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE17
        st_ff.tx_busy && !i_sync_rst |=> o_txd_oe) else $error("driver released mid frame");
    dbl_samples_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE3
        !i_sync_mode_sel && i_double_speed_sel && st_ff.tx_busy && tick && st_ff.tx_smp == 4'h7 && !i_sync_rst
        |=> st_ff.tx_smp == 4'h0) else $error("double speed bit length wrong");

    frame_done_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) $rose(st_ff.transmit_complete_flag));
    rx_push_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) st_ff.push);
    rx_perr_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) st_ff.push && st_ff.push_word[FW_PE]);
    rx_over_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) decide && !fifo_ready);
endmodule // usp_serial_port

/* File: core/usp_pkg.sv */
package usp_pkg;
    // divider width and data width
    localparam int          DIV_W        = 12;
    localparam int          DATA_W       = 8;
    localparam int          FRAME_W      = 13;       // start + 9 data + parity + 2 stop
    // samples per bit, last sample index, majority vote window
    localparam logic [3:0]  SMP_LAST_N   = 4'hF;     // 16 samples in normal speed
    localparam logic [3:0]  SMP_LAST_D   = 4'h7;     // 8 samples in double speed
    localparam logic [3:0]  VOTE_FIRST_N = 4'h7;
    localparam logic [3:0]  VOTE_LAST_N  = 4'h9;
    localparam logic [3:0]  VOTE_FIRST_D = 4'h3;
    localparam logic [3:0]  VOTE_LAST_D  = 4'h5;
    // character size codes
    localparam logic [2:0]  CSZ_NINE     = 3'h7;
    localparam logic [3:0]  NBITS_MIN    = 4'h5;
    localparam logic [3:0]  NBITS_EIGHT  = 4'h8;
    localparam logic [3:0]  NBITS_NINE   = 4'h9;
    // parity mode field positions
    localparam int          PAR_EN_BIT   = 1;
    localparam int          PAR_ODD_BIT  = 0;
    // receive fifo word layout
    localparam int          FW_NINTH     = 8;
    localparam int          FW_PE        = 9;
    localparam int          FW_DOR       = 10;
    localparam int          FW_FE        = 11;
    localparam int          FIFO_W       = 12;
    localparam int          FIFO_DEPTH   = 8;
    // reset values
    localparam logic        TXD_IDLE     = 1'b1;
    localparam logic        SCLK_RST     = 1'b0;
endpackage

/* File: core/usp_fifo.sv */
`timescale 1ns/1ps
module usp_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_clr,        // synchronous flush
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);

    // pointers carry one extra bit so full and empty differ
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } usp_fifo_st_t;

    usp_fifo_st_t st_ff;
    usp_fifo_st_t nxt_st;
    logic         full;
    logic         empty;

    assign empty       = (st_ff.wp == st_ff.rp);
    assign full        = (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]) && (st_ff.wp[AW] != st_ff.rp[AW]);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = st_ff.mem[st_ff.rp[AW-1:0]];

    // push and pop, flush overrides both
    always_comb begin
        nxt_st = st_ff;
        if (i_in_valid && !full) begin
            nxt_st.mem[st_ff.wp[AW-1:0]] = i_in_data;
            nxt_st.wp                    = st_ff.wp + 1'b1;
        end
        if (i_out_ready && !empty) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (i_clr) begin
            nxt_st.wp = '0;
            nxt_st.rp = '0;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // a flush may rewind the write pointer even while full
    fifo_noover_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE18
        full && !i_out_ready && !i_clr |=> st_ff.wp == $past(st_ff.wp)) else $error("fifo overwritten while full");
endmodule // usp_fifo

/* File: tb/usp_remote_uart.sv */
`timescale 1ns/1ps
// remote party: sends raw frames on the receive line, captures frames off the transmit line
module usp_remote_uart (
    input  wire logic        i_sys_clk,
    input  wire logic [7:0]  i_bit_cycles,  // clocks per bit
    input  wire logic        i_go,          // send i_frame
    input  wire logic [11:0] i_frame,       // start bit at index 0
    input  wire logic        i_txd,
    output logic             o_rxd,
    output logic [11:0]      o_got          // bits seen after a start bit
);
    initial o_rxd = 1'h1;
    // send lsb first, line falls back to idle high after the frame
    always @(posedge i_go) begin
        for (int i = 0; i < 12; i++) begin
            o_rxd <= i_frame[i];
            repeat (i_bit_cycles) @(posedge i_sys_clk);
        end
        o_rxd <= 1'h1;
    end
    // centre sampling; edges inside a frame are ignored while busy
    always @(negedge i_txd) begin
        repeat (i_bit_cycles / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 12; i++) begin
            repeat (i_bit_cycles) @(posedge i_sys_clk);
            o_got[i] <= i_txd;
        end
    end
endmodule // usp_remote_uart

/* File: tb/test_usp_serial_port.sv */
`timescale 1ns/1ps
module test_usp_serial_port;
    import usp_pkg::*;
    logic i_sys_clk, i_rstn, i_sync_rst, i_double_speed_sel, i_sync_mode_sel, i_clock_master_sel, go;
    logic i_clock_polarity_sel, i_stop_two_sel, i_transmitter_enable, i_receiver_enable, i_tx_write;
    logic i_transmit_ninth_bit, i_txc_clear, i_txc_irq_ack, i_transmit_complete_irq_en, i_global_irq_en;
    logic i_rxd, i_serial_clock_pin, i_rx_read, o_tx_ready, o_transmit_complete_flag, o_txc_irq, o_txd;
    logic o_txd_oe, o_serial_clock_pin, o_serial_clock_pin_oe, o_rx_valid, o_received_ninth_bit;
    logic o_frame_error_flag, o_overrun_flag, o_parity_error_flag;
    logic [3:0] i_baud_divider_high;
    logic [7:0] i_baud_divider_low, i_serial_data_reg, o_rx_data, bitc;
    logic [1:0] i_parity_mode;
    logic [2:0] i_character_size_code;
    logic [11:0] frame, got;
    int mismatches, checks_done;
    usp_serial_port i_dut (.i_sys_clk, .i_rstn, .i_sync_rst, .i_baud_divider_high, .i_baud_divider_low,
        .i_double_speed_sel, .i_sync_mode_sel, .i_clock_master_sel, .i_clock_polarity_sel, .i_parity_mode,
        .i_stop_two_sel, .i_character_size_code, .i_transmitter_enable, .i_receiver_enable,
        .i_serial_data_reg, .i_transmit_ninth_bit, .i_tx_write, .o_tx_ready, .i_txc_clear, .i_txc_irq_ack,
        .i_transmit_complete_irq_en, .i_global_irq_en, .o_transmit_complete_flag, .o_txc_irq, .i_rxd,
        .o_txd, .o_txd_oe, .i_serial_clock_pin, .o_serial_clock_pin, .o_serial_clock_pin_oe, .i_rx_read,
        .o_rx_valid, .o_rx_data, .o_received_ninth_bit, .o_frame_error_flag, .o_overrun_flag,
        .o_parity_error_flag);
    usp_remote_uart i_far (.i_sys_clk, .i_bit_cycles(bitc), .i_go(go), .i_frame(frame), .i_txd(o_txd),
        .o_rxd(i_rxd), .o_got(got));
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one character into the transmit buffer once it is free
    task automatic send(input logic [7:0] d);
        for (int k = 0; k < 999 && o_tx_ready !== 1'h1; k++) cyc(1);
        i_serial_data_reg <= d;
        i_tx_write <= 1'h1;
        cyc(1);
        i_tx_write <= 1'h0;
    endtask
    // received word r: nine data bits, odd parity, r==1 bad parity, r==2 bad stop
    function automatic logic [11:0] mk(input int r);
        logic [8:0] d;
        d = 9'h155 ^ 9'(r);
        return {r != 2, ~^d ^ (r == 1), d, 1'h0};
    endfunction
    task automatic rd(input int r, input logic ov);
        chk({o_overrun_flag, o_frame_error_flag, o_parity_error_flag, o_received_ninth_bit, o_rx_data},
            {ov, r == 2, r == 1, 9'h155 ^ 9'(r)});
        i_rx_read <= 1'h1;
        cyc(1);
        i_rx_read <= 1'h0;
        cyc(1);
    endtask
    initial begin
        {i_rstn, i_sync_rst, i_double_speed_sel, i_sync_mode_sel, i_clock_master_sel, i_clock_polarity_sel,
         i_stop_two_sel, i_transmitter_enable, i_receiver_enable, i_tx_write, i_transmit_ninth_bit,
         i_txc_clear, i_txc_irq_ack, i_transmit_complete_irq_en, i_global_irq_en, i_serial_clock_pin,
         i_rx_read, go, i_baud_divider_high, i_parity_mode, i_character_size_code, i_serial_data_reg} = '0;
        {i_sys_clk, mismatches, checks_done, frame, bitc, i_baud_divider_low} = {1'h0, 64'h0, 12'hFFF, 16'h2001};
        cyc(5);
        chk({o_txd, o_txd_oe, o_transmit_complete_flag, o_rx_valid}, 4'h8);
        {i_rstn, i_transmitter_enable, i_receiver_enable, i_transmit_complete_irq_en} <= 4'hF;
        i_character_size_code <= 3'h3;
        // pass 0 normal speed, even, irq on, flag clear; pass 1 double speed, odd, masked, ack, disable
        for (int ds = 0; ds < 2; ds++) begin
            {i_double_speed_sel, i_stop_two_sel, i_parity_mode} <= {ds[0], ds[0], 1'h1, ds[0]};
            {bitc, i_global_irq_en} <= {ds[0] ? 8'h10 : 8'h20, ~ds[0]};
            send(ds[0] ? 8'h3C : 8'hA5);
            i_transmitter_enable <= ~ds[0];
            cyc(4 * bitc);
            chk({o_txd_oe, o_tx_ready}, 2'h3);
            for (int k = 0; k < 999 && o_transmit_complete_flag !== 1'h1; k++) cyc(1);
            chk({o_txc_irq, o_txd}, {~ds[0], 1'h1});
            {i_txc_clear, i_txc_irq_ack} <= {~ds[0], ds[0]};
            cyc(1);
            {i_txc_clear, i_txc_irq_ack} <= 2'h0;
            cyc(2 * bitc);
            chk({o_transmit_complete_flag, o_txd_oe, o_tx_ready}, {1'h0, ~ds[0], ~ds[0]});
            chk(got, {3'h7, ^(ds[0] ? 8'h3C : 8'hA5) ^ ds[0], ds[0] ? 8'h3C : 8'hA5});
        end
        {i_double_speed_sel, i_character_size_code, bitc} <= {1'h0, CSZ_NINE, 8'h20};
        // nine frames fill and overflow the fifo, then drain and show the overrun
        for (int r = 0; r < 10; r++) begin
            if (r == 9) for (int k = 0; k < 8; k++) rd(k, 1'h0);
            {frame, go} <= {mk(r), 1'h1};
            cyc(1);
            go <= 1'h0;
            cyc(14 * bitc);
        end
        rd(9, 1'h1);
        chk(o_rx_valid, 1'h0);
        // sync slave receive, then master clock, then sync clear
        {i_sync_mode_sel, bitc} <= {1'h1, 8'h8};
        cyc(2);
        chk({o_serial_clock_pin_oe, o_rx_valid}, 2'h0);
        {frame, go} <= {mk(3), 1'h1};
        for (int i = 1; i < 25; i++) begin
            cyc(4);
            {go, i_serial_clock_pin} <= {1'h0, i[0]};
        end
        cyc(2);
        rd(3, 1'h0);
        i_clock_master_sel <= 1'h1;
        cyc(9);
        i_sync_rst <= 1'h1;
        cyc(2);
        chk({o_serial_clock_pin_oe, o_serial_clock_pin, o_txd}, 3'h5);
        wrap_up;
    end
    initial begin
        cyc(20000);
        mismatches++;
        wrap_up;
    end
endmodule // test_usp_serial_port
